/* File: opm_consts.svh */
// Purpose: shared constants for the PROM map and programming link
// Assumes: 50 MHz hclk
// Notes: times in their own unit, cycle counts derived from them
`ifndef OPM_CONSTS_SVH
`define OPM_CONSTS_SVH
`define OPM_CLK_MHZ      50
`define OPM_WORDS_LARGE  32768
`define OPM_WORDS_SMALL  16384
// memory map register fields
`define OPM_RANGE_MSB    7
`define OPM_RANGE_LSB    5
`define OPM_RAE_BIT      3
`define OPM_PORT_MSB     2
`define OPM_RANGE_RST    3'h0
`define OPM_RAE_RST      1'b0
`define OPM_PORT_RST     3'h0
// range codes
`define OPM_R_32K        3'h0
`define OPM_R_16K        3'h1
`define OPM_R_8K         3'h3
`define OPM_R_4K         3'h5
`define OPM_LAST_32K     16'h7FFF
`define OPM_LAST_16K     16'h3FFF
`define OPM_LAST_8K      16'h1FFF
`define OPM_LAST_4K      16'h0FFF
`define OPM_RAM_1K       16'hFC00
`define OPM_RAM_256      16'hFF00
// port use codes
`define OPM_P_IN         3'h0
`define OPM_P_OUT        3'h1
`define OPM_P_X256       3'h2
`define OPM_P_X4K        3'h4
`define OPM_P_X16K       3'h6
`define OPM_P_XFULL      3'h7
// programming timing
`define OPM_TPULSE_US    1000
`define OPM_TOVER_US     3000
`define OPM_MAX_TRIES    25
`define OPM_TSETUP_NS    2000
`define OPM_TOE_NS       200
`define OPM_SETUP_CYC    ((`OPM_TSETUP_NS * `OPM_CLK_MHZ + 999) / 1000)
`define OPM_OE_CYC       ((`OPM_TOE_NS * `OPM_CLK_MHZ + 999) / 1000)
// programmer register offsets
`define OPM_A_CTRL       8'h00
`define OPM_A_ADDR       8'h04
`define OPM_A_LAST       8'h08
`define OPM_A_DATA       8'h0C
`define OPM_A_READ       8'h10
`define OPM_A_STAT       8'h14
`endif

/* File: opm_pkg.sv */
// Purpose: types for the PROM map and programming link
// Assumes: nothing
// Notes: codes written out in binary
package opm_pkg;
    typedef enum logic [3:0] {
        OPM_IDLE   = 4'b0000,
        OPM_SETUP  = 4'b0001,
        OPM_PULSE  = 4'b0010,
        OPM_HOLD   = 4'b0011,
        OPM_VERIFY = 4'b0100,
        OPM_OSETUP = 4'b0101,
        OPM_OPULSE = 4'b0110,
        OPM_NEXT   = 4'b0111,
        OPM_READ   = 4'b1000
    } opm_pstate_t;
    typedef enum logic [1:0] {
        OPM_D_IN  = 2'b00,
        OPM_D_OUT = 2'b01,
        OPM_D_BUS = 2'b10
    } opm_port_use_t;
endpackage

/* File: opm_link_if.sv */
// Purpose: programming pins between programmer and device
// Assumes: one hclk for both ends
// Notes: data pin level resolved here from the two enables
interface opm_link_if;
    logic [14:0] prom_address_pins;
    logic [7:0]  prog_data;
    logic        prog_data_oe;
    logic [7:0]  dev_data;
    logic        dev_data_oe;
    logic [7:0]  prom_data_pins;
    logic        ce_n;
    logic        oe_n;
    logic        vpp_high;
    logic        vdd_high;
    logic        pin_reset_n;
    logic        strap_pin_0;
    logic        strap_pin_1;
    logic        programming_strap_low;
    // undriven bus floats high
    assign prom_data_pins = dev_data_oe ? dev_data :
                            (prog_data_oe ? prog_data : 8'hFF);
    modport device (
        input  prom_address_pins, prom_data_pins, ce_n, oe_n,
        input  vpp_high, vdd_high, pin_reset_n,
        input  strap_pin_0, strap_pin_1, programming_strap_low,
        output dev_data, dev_data_oe
    );
    modport programmer (
        output prom_address_pins, prog_data, prog_data_oe, ce_n, oe_n,
        output vpp_high, vdd_high, pin_reset_n,
        output strap_pin_0, strap_pin_1, programming_strap_low,
        input  prom_data_pins
    );
endinterface

/* File: opm_device_end.sv */
// Purpose: on-chip program PROM, memory map control, programming port
// Assumes: pins synchronous to hclk; supplies arrive as level flags
// Notes: PROM array is not reset; it starts erased (all ones)
// How it works
// R1: range bits pick PROM range, RAM window
// R2: software writes only defined range codes
// R3: 32K code exists only on large variant
// R4: stop or reset clears the range bits
// R5: mask ROM parts ignore range writes
// R6: bit 3 enables internal RAM access
// R7: bits 2..0 pick port use, expansion
// R8: PROM holds 32768 or 16384 bytes
// R9: programmer holds reset low, sets straps
// R10: 15/14-bit address, two-way data port
// R11: strobes at high supply program/verify
// R12: never both strobes low at high supply
// R13: read at 5 V drives data pins
// R14: 1 ms low program pulse per byte
// R15: verify, retry, reject after 25 tries
// R16: extra pulse, tries times 3 ms
// R17: step address up to final address
// R18: inhibit, disable: no change, no drive
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`include "opm_consts.svh"
module opm_device_end
    import opm_pkg::*;
#(
    parameter int PROM_WORDS = `OPM_WORDS_LARGE,
    parameter bit HAS_PROM   = 1'b1
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    opm_link_if.device       link,
    input  wire logic        cpu_mm_we,
    input  wire logic [7:0]  cpu_mm_wdata,
    input  wire logic        cpu_stop,
    input  wire logic [15:0] cpu_addr,
    output logic [7:0]       mm_rdata,
    output logic             prom_sel,
    output logic             ram_sel,
    output logic             ext_sel,
    output logic [7:0]       cpu_prom_data,
    output opm_port_use_t    port_d_use,
    output logic [7:0]       port_f_addr_mask
);
    localparam int AW    = $clog2(PROM_WORDS);
    localparam bit LARGE = (PROM_WORDS >= `OPM_WORDS_LARGE);

    // program memory array
    logic [7:0] mem [PROM_WORDS]; // R8

    logic [2:0]      range_r;
    logic [2:0]      range_nxt;
    logic            rae_r;
    logic            rae_nxt;
    logic [2:0]      port_r;
    logic [2:0]      port_nxt;
    logic [15:0]     prom_last;
    logic [15:0]     ram_base;
    logic            prom_hit;
    logic            ram_hit;
    logic            ext_hit;
    opm_port_use_t   d_use;
    logic [7:0]      f_mask;
    logic            prom_sel_r;
    logic            ram_sel_r;
    logic            ext_sel_r;
    logic [7:0]      cpu_data_r;
    opm_port_use_t   d_use_r;
    logic [7:0]      f_mask_r;
    logic            prog_mode;
    logic            hi_supply;
    logic            lo_supply;
    logic            do_prog;
    logic            do_verify;
    logic            do_read;
    logic [AW-1:0]   pa;
    logic            drive_r;
    logic            drive_nxt;
    logic [7:0]      dout_r;

    initial begin
        for (int i = 0; i < PROM_WORDS; i++) begin
            mem[i] = 8'hFF;
        end
    end

    // memory map register next values
    always_comb begin
        range_nxt = range_r;
        rae_nxt   = rae_r;
        port_nxt  = port_r;
        if (cpu_mm_we) begin
            if (HAS_PROM) begin // R5
                range_nxt = cpu_mm_wdata[`OPM_RANGE_MSB:`OPM_RANGE_LSB]; // R1
            end
            rae_nxt  = cpu_mm_wdata[`OPM_RAE_BIT]; // R6
            port_nxt = cpu_mm_wdata[`OPM_PORT_MSB:0]; // R7
        end
        // stop wins over a range write in the same cycle; bit 3 and the port bits still take the write
        if (cpu_stop) begin
            range_nxt = `OPM_RANGE_RST; // R4
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            range_r <= `OPM_RANGE_RST; // R4
            rae_r   <= `OPM_RAE_RST;
            port_r  <= `OPM_PORT_RST;
        end else begin
            range_r <= range_nxt;
            rae_r   <= rae_nxt;
            port_r  <= port_nxt;
        end
    end

    // reserved bit 4 reads zero
    assign mm_rdata = {range_r, 1'b0, rae_r, port_r};

    // range decode; mask ROM parts keep their full array
    always_comb begin
        prom_last = 16'(PROM_WORDS - 1);
        ram_base  = `OPM_RAM_256;
        if (HAS_PROM) begin
            case (range_r)
                `OPM_R_32K: begin
                    // small variant has no 32K code: its cleared state is 16K
                    prom_last = LARGE ? `OPM_LAST_32K : `OPM_LAST_16K; // R3
                    ram_base  = LARGE ? `OPM_RAM_1K : `OPM_RAM_256; // R1
                end
                `OPM_R_16K: begin
                    prom_last = `OPM_LAST_16K; // R1
                end
                `OPM_R_8K: begin
                    prom_last = `OPM_LAST_8K; // R1
                end
                `OPM_R_4K: begin
                    prom_last = `OPM_LAST_4K; // R1
                end
                default: begin
                    // prohibited code: fall back to the smallest range
                    prom_last = `OPM_LAST_4K;
                end
            endcase
        end else if (LARGE) begin
            ram_base = `OPM_RAM_1K;
        end
    end

    // port use and upper address lines
    always_comb begin
        d_use  = OPM_D_IN;
        f_mask = 8'h00;
        case (port_r)
            `OPM_P_IN: begin
                d_use = OPM_D_IN; // R7
            end
            `OPM_P_OUT: begin
                d_use = OPM_D_OUT; // R7
            end
            `OPM_P_X256: begin
                d_use = OPM_D_BUS; // R7
            end
            `OPM_P_X4K: begin
                d_use  = OPM_D_BUS;
                f_mask = 8'h0F; // R7
            end
            `OPM_P_X16K: begin
                d_use  = OPM_D_BUS;
                f_mask = 8'h3F; // R7
            end
            `OPM_P_XFULL: begin
                d_use  = OPM_D_BUS;
                f_mask = 8'hFF; // R7
            end
            default: begin
                d_use  = OPM_D_IN;
                f_mask = 8'h00;
            end
        endcase
    end

    // address decode for the cpu side
    always_comb begin
        prom_hit = (cpu_addr <= prom_last); // R1
        ram_hit  = rae_r && (cpu_addr >= ram_base); // R6
        ext_hit  = !prom_hit && !ram_hit && (d_use == OPM_D_BUS);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prom_sel_r <= 1'b0;
            ram_sel_r  <= 1'b0;
            ext_sel_r  <= 1'b0;
            d_use_r    <= OPM_D_IN;
            f_mask_r   <= 8'h00;
        end else begin
            prom_sel_r <= prom_hit;
            ram_sel_r  <= ram_hit;
            ext_sel_r  <= ext_hit;
            d_use_r    <= d_use;
            f_mask_r   <= f_mask;
        end
    end

    assign prom_sel         = prom_sel_r;
    assign ram_sel          = ram_sel_r;
    assign ext_sel          = ext_sel_r;
    assign port_d_use       = d_use_r;
    assign port_f_addr_mask = f_mask_r;

    // programming pin decode; small part also needs its extra strap low
    always_comb begin
        prog_mode = !link.pin_reset_n && link.strap_pin_0 &&
                    !link.strap_pin_1 &&
                    (LARGE || !link.programming_strap_low); // R9
        hi_supply = link.vpp_high && link.vdd_high;
        lo_supply = !link.vpp_high && !link.vdd_high;
        do_prog   = prog_mode && hi_supply &&
                    !link.ce_n && link.oe_n; // R11
        do_verify = prog_mode && hi_supply &&
                    link.ce_n && !link.oe_n; // R11
        do_read   = prog_mode && lo_supply &&
                    !link.ce_n && !link.oe_n; // R13
        // inhibit, output disable and standby leave the pins free
        drive_nxt = do_verify || do_read; // R18
        pa        = link.prom_address_pins[AW-1:0]; // R10
    end

    // eprom cells only lose ones, so the write is an and
    always_ff @(posedge hclk) begin
        if (do_prog) begin
            mem[pa] <= mem[pa] & link.prom_data_pins; // R11
        end
        dout_r     <= mem[pa]; // R10
        cpu_data_r <= mem[cpu_addr[AW-1:0]];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_r <= 1'b0;
        end else begin
            drive_r <= drive_nxt; // R18
        end
    end

    // data and enable both lag the pins by one edge
    assign link.dev_data    = dout_r;
    assign link.dev_data_oe = drive_r; // R13
    assign cpu_prom_data    = cpu_data_r;
endmodule

/* File: opm_programmer_end.sv */
// Purpose: PROM programmer driven by software over AHB-Lite
// Assumes: single word transfers; response always OKAY
// Notes: a data write stalls while the previous byte is in progress
`include "opm_consts.svh"
module opm_programmer_end
    import opm_pkg::*;
#(
    parameter int PULSE_CYC = `OPM_TPULSE_US * `OPM_CLK_MHZ,
    parameter int OVER_CYC  = `OPM_TOVER_US * `OPM_CLK_MHZ,
    parameter int MAX_TRIES = `OPM_MAX_TRIES
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic        hwrite,
    input  wire logic [1:0]  htrans,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    opm_link_if.programmer   link
);
    opm_pstate_t st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [7:0]  tries_r, tries_nxt, rep_r, rep_nxt;
    logic [14:0] addr_r, addr_nxt, last_r, last_nxt;
    logic [7:0]  wdat_r, wdat_nxt, rdat_r, rdat_nxt;
    logic        en_r, en_nxt, fail_r, fail_nxt, done_r, done_nxt;
    logic        dp_r, dpw_r, busy, wr_ok, ce_n_r, ce_n_nxt;
    logic [7:0]  dpa_r;
    logic        oe_n_r, oe_n_nxt, vpp_r, vpp_nxt, dlo_r, dlo_nxt;
    logic [31:0] hrdata_r;

    assign busy  = (st_r != OPM_IDLE);
    // byte commands wait for the sequencer; other writes go through
    assign hreadyout = !(dp_r && dpw_r && busy &&
                        (dpa_r == `OPM_A_DATA || dpa_r == `OPM_A_READ));
    assign wr_ok  = dp_r && dpw_r && hreadyout;
    assign hresp  = 1'b0;
    assign hrdata = hrdata_r;

    // address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_r     <= 1'b0;
            dpw_r    <= 1'b0;
            dpa_r    <= 8'h00;
            hrdata_r <= 32'h0;
        end else if (hready) begin
            dp_r  <= hsel && htrans[1];
            dpw_r <= hwrite;
            dpa_r <= haddr[7:0];
            if (haddr[7:0] == `OPM_A_CTRL) hrdata_r <= {31'h0, en_r};
            else if (haddr[7:0] == `OPM_A_ADDR) hrdata_r <= {17'h0, addr_r};
            else if (haddr[7:0] == `OPM_A_LAST) hrdata_r <= {17'h0, last_r};
            else if (haddr[7:0] == `OPM_A_READ) hrdata_r <= {24'h0, rdat_r};
            else if (haddr[7:0] == `OPM_A_STAT)
                hrdata_r <= {16'h0, tries_r, 5'h0, done_r, fail_r, busy};
            else hrdata_r <= 32'h0;
        end
    end

    // sequencer next state
    always_comb begin
        st_nxt = st_r; cnt_nxt = cnt_r + 32'h1; tries_nxt = tries_r;
        rep_nxt = rep_r; addr_nxt = addr_r; last_nxt = last_r;
        wdat_nxt = wdat_r; rdat_nxt = rdat_r; en_nxt = en_r;
        fail_nxt = fail_r; done_nxt = done_r;
        if (wr_ok && dpa_r == `OPM_A_CTRL) en_nxt = hwdata[0];
        if (wr_ok && dpa_r == `OPM_A_ADDR) addr_nxt = hwdata[14:0];
        if (wr_ok && dpa_r == `OPM_A_LAST) last_nxt = hwdata[14:0];
        if (wr_ok && dpa_r == `OPM_A_STAT) begin
            fail_nxt = fail_r && !hwdata[1];
            done_nxt = done_r && !hwdata[2];
        end
        case (st_r)
            OPM_IDLE: begin
                cnt_nxt = 32'h0;
                if (wr_ok && dpa_r == `OPM_A_DATA) begin
                    wdat_nxt = hwdata[7:0]; tries_nxt = 8'h0;
                    st_nxt = OPM_SETUP;
                end else if (wr_ok && dpa_r == `OPM_A_READ) begin
                    st_nxt = OPM_READ;
                end
            end
            OPM_SETUP: if (cnt_r == `OPM_SETUP_CYC - 1) begin
                cnt_nxt = 32'h0; tries_nxt = tries_r + 8'h1;
                st_nxt = OPM_PULSE;
            end
            OPM_PULSE: if (cnt_r == PULSE_CYC - 1) begin // R14
                cnt_nxt = 32'h0; st_nxt = OPM_HOLD;
            end
            OPM_HOLD: if (cnt_r == `OPM_SETUP_CYC - 1) begin
                cnt_nxt = 32'h0; st_nxt = OPM_VERIFY;
            end
            OPM_VERIFY: if (cnt_r == `OPM_OE_CYC - 1) begin
                cnt_nxt = 32'h0;
                if (link.prom_data_pins == wdat_r) begin
                    rep_nxt = tries_r; st_nxt = OPM_OSETUP;
                end else if (tries_r == 8'(MAX_TRIES)) begin // R15
                    fail_nxt = 1'b1; st_nxt = OPM_IDLE;
                end else st_nxt = OPM_SETUP; // R15
            end
            OPM_OSETUP: if (cnt_r == `OPM_SETUP_CYC - 1) begin
                cnt_nxt = 32'h0; st_nxt = OPM_OPULSE;
            end
            OPM_OPULSE: if (cnt_r == OVER_CYC - 1) begin // R16
                cnt_nxt = 32'h0; rep_nxt = rep_r - 8'h1;
                if (rep_r == 8'h1) st_nxt = OPM_NEXT;
            end
            OPM_NEXT: begin
                if (addr_r == last_r) done_nxt = 1'b1; // R17
                else addr_nxt = addr_r + 15'h1; // R17
                st_nxt = OPM_IDLE;
            end
            OPM_READ: if (cnt_r == `OPM_OE_CYC - 1) begin // R13
                rdat_nxt = link.prom_data_pins; st_nxt = OPM_IDLE;
            end
            default: st_nxt = OPM_IDLE;
        endcase
        // pins follow the next state; strobes never both low at high supply
        vpp_nxt  = (st_nxt != OPM_IDLE) && (st_nxt != OPM_READ); // R11
        ce_n_nxt = !(st_nxt == OPM_PULSE || st_nxt == OPM_OPULSE ||
                     st_nxt == OPM_READ); // R12
        oe_n_nxt = !(st_nxt == OPM_VERIFY || st_nxt == OPM_READ); // R12
        // one idle cycle after verify: the device lets go one edge late
        dlo_nxt  = (st_nxt == OPM_SETUP || st_nxt == OPM_PULSE ||
                    st_nxt == OPM_OSETUP || st_nxt == OPM_OPULSE) &&
                   (st_r != OPM_VERIFY); // R10
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= OPM_IDLE; cnt_r <= 32'h0; tries_r <= 8'h0;
            rep_r <= 8'h0; addr_r <= 15'h0; last_r <= 15'h0;
            wdat_r <= 8'h00; rdat_r <= 8'h00; en_r <= 1'b0;
            fail_r <= 1'b0; done_r <= 1'b0; ce_n_r <= 1'b1;
            oe_n_r <= 1'b1; vpp_r <= 1'b0; dlo_r <= 1'b0;
        end else begin
            st_r <= st_nxt; cnt_r <= cnt_nxt; tries_r <= tries_nxt;
            rep_r <= rep_nxt; addr_r <= addr_nxt; last_r <= last_nxt;
            wdat_r <= wdat_nxt; rdat_r <= rdat_nxt; en_r <= en_nxt;
            fail_r <= fail_nxt; done_r <= done_nxt; ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt; vpp_r <= vpp_nxt; dlo_r <= dlo_nxt;
        end
    end

    // session straps hold the device in programming mode
    assign link.pin_reset_n           = !en_r; // R9
    assign link.strap_pin_0           = en_r; // R9
    assign link.strap_pin_1           = 1'b0; // R9
    assign link.programming_strap_low = 1'b0; // R9
    assign link.prom_address_pins     = addr_r;
    assign link.prog_data             = wdat_r;
    assign link.prog_data_oe          = dlo_r;
    assign link.ce_n                  = ce_n_r;
    assign link.oe_n                  = oe_n_r;
    assign link.vpp_high              = vpp_r;
    assign link.vdd_high              = vpp_r;
endmodule

/* File: opm_link_properties.sv */
// Purpose: wire checks on the programming link
// Assumes: one clock; pulse counts as set on the programmer
// Notes: strobe low time counted in helper logic
module opm_link_properties #(
    parameter int PULSE_CYC = 20,
    parameter int OVER_CYC  = 30
)(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [14:0] prom_address_pins,
    input wire logic        prog_data_oe,
    input wire logic        dev_data_oe,
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        vpp_high,
    input wire logic        pin_reset_n,
    input wire logic        strap_pin_0,
    input wire logic        strap_pin_1
);
    logic [15:0] low_cnt_r;
    logic [15:0] low_cnt_nxt;
    logic        mode;
    logic        drive;
    // verify at high supply, read at low supply
    assign mode  = !pin_reset_n && strap_pin_0 && !strap_pin_1;
    assign drive = mode && !oe_n && (vpp_high ? ce_n : !ce_n);
    // ce_n low time, cleared while high
    always_comb low_cnt_nxt = ce_n ? 16'h0000 : low_cnt_r + 16'h0001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            low_cnt_r <= 16'h0000;
        else
            low_cnt_r <= low_cnt_nxt;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    strobe_clash_a: assert property (vpp_high |-> ce_n || oe_n)
        else $error("both strobes low at high supply");
    strap_hold_a: assert property (vpp_high |-> mode)
        else $error("high supply outside programming mode");
    pulse_len_a: assert property ($rose(ce_n) && vpp_high |->
        low_cnt_r == PULSE_CYC || low_cnt_r % OVER_CYC == 0)
        else $error("program pulse of wrong length");
    pulse_setup_a: assert property (!ce_n && vpp_high |->
        prog_data_oe && $stable(prom_address_pins))
        else $error("data or address not held in pulse");
    answer_a: assert property (drive |=> dev_data_oe)
        else $error("device silent in verify or read");
    quiet_a: assert property (!drive |=> !dev_data_oe)
        else $error("device drives outside verify or read");
    no_fight_a: assert property (!(dev_data_oe && prog_data_oe))
        else $error("both ends drive the data pins");
    oe_width_a: assert property ($fell(oe_n) |-> !oe_n [*8])
        else $error("output enable pulse too short");
endmodule

/* File: onchip_prom_map_and_program_tb_top.sv */
// Purpose: self-checking bench for the PROM map and programming link
// Assumes: large part, short pulse counts
// Notes: inputs change after rising edges, checks at falling edges
`include "opm_consts.svh"
module onchip_prom_map_and_program_tb_top
    import opm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TRIES = 3;
    logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic          cpu_mm_we, cpu_stop, prom_sel, ram_sel, ext_sel;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic [31:0]   haddr, hwdata, hrdata, rdata;
    logic [7:0]    cpu_mm_wdata, mm_rdata, cpu_prom_data, port_f_addr_mask;
    logic [15:0]   cpu_addr;
    opm_port_use_t port_d_use;
    int            mismatches = 0, samples_checked = 0, cycles = 0;
    opm_link_if link ();
    assign hready = hreadyout;
    opm_device_end opm_device_end_inst (
        .hclk(hclk), .hresetn(hresetn), .link(link), .cpu_mm_we(cpu_mm_we),
        .cpu_mm_wdata(cpu_mm_wdata), .cpu_stop(cpu_stop), .cpu_addr(cpu_addr),
        .mm_rdata(mm_rdata), .prom_sel(prom_sel), .ram_sel(ram_sel), .ext_sel(ext_sel),
        .cpu_prom_data(cpu_prom_data), .port_d_use(port_d_use),
        .port_f_addr_mask(port_f_addr_mask));
    opm_programmer_end #(.PULSE_CYC(20), .OVER_CYC(30), .MAX_TRIES(TRIES))
        opm_programmer_end_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
        .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
    opm_link_properties #(.PULSE_CYC(20), .OVER_CYC(30)) opm_link_properties_inst (
        .hclk(hclk), .hresetn(hresetn), .prom_address_pins(link.prom_address_pins),
        .prog_data_oe(link.prog_data_oe), .dev_data_oe(link.dev_data_oe),
        .ce_n(link.ce_n), .oe_n(link.oe_n), .vpp_high(link.vpp_high),
        .pin_reset_n(link.pin_reset_n), .strap_pin_0(link.strap_pin_0),
        .strap_pin_1(link.strap_pin_1));
    // 50 MHz clock
    always #10 hclk = ~hclk;
    // hang guard, far above the few thousand cycles needed
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // hready seen high at an edge; data taken from before that edge
    task automatic rdy();
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
        @(posedge hclk);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask
    // poll status until the sequencer is idle
    task automatic idle_wait();
        do ahb(1'b0, `OPM_A_STAT, 32'h0);
        while (rdata[0] !== 1'b0);
    endtask
    task automatic prog(input logic [14:0] a, input logic [14:0] last, input logic [7:0] d);
        ahb(1'b1, `OPM_A_ADDR, {17'h00000, a});
        ahb(1'b1, `OPM_A_LAST, {17'h00000, last});
        ahb(1'b1, `OPM_A_DATA, {24'h000000, d});
        idle_wait();
    endtask
    // cpu side: derived registers settle one edge after the write
    task automatic mm_wr(input logic [7:0] v, input logic stop);
        @(posedge hclk);
        cpu_mm_we    <= 1'b1;
        cpu_stop     <= stop;
        cpu_mm_wdata <= v;
        @(posedge hclk);
        {cpu_mm_we, cpu_stop} <= 2'b00;
        @(posedge hclk);
        @(negedge hclk);
    endtask
    task automatic sel(input logic [15:0] a, input logic [2:0] e);
        @(posedge hclk);
        cpu_addr <= a;
        @(posedge hclk);
        @(negedge hclk);
        chk({prom_sel, ram_sel, ext_sel}, e);
    endtask
    task automatic t_map();
        logic [2:0]  code [4] = '{`OPM_R_32K, `OPM_R_16K, `OPM_R_8K, `OPM_R_4K};
        logic [15:0] top [4]  = '{16'h7FFF, 16'h3FFF, 16'h1FFF, 16'h0FFF};
        chk(mm_rdata, 32'h0);
        for (int i = 0; i < 4; i++) begin
            mm_wr({code[i], 5'h08}, 1'b0);
            chk(mm_rdata, {code[i], 5'h08});
            sel(top[i], 3'b100);
            sel(top[i] + 16'h0001, 3'b000);
            sel((i == 0) ? 16'hFC00 : 16'hFF00, 3'b010);
            sel((i == 0) ? 16'hFBFF : 16'hFEFF, 3'b000);
        end
        mm_wr(8'h00, 1'b0);
        sel(16'hFF00, 3'b000);
        mm_wr(8'hA8, 1'b0);
        mm_wr(8'hA8, 1'b1);
        chk(mm_rdata, 32'h08);
    endtask
    task automatic t_port();
        logic [2:0] c [6] = '{`OPM_P_IN, `OPM_P_OUT, `OPM_P_X256, `OPM_P_X4K,
                              `OPM_P_X16K, `OPM_P_XFULL};
        logic [7:0] m [6] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h3F, 8'hFF};
        for (int i = 0; i < 6; i++) begin
            mm_wr({5'h00, c[i]}, 1'b0);
            chk({port_d_use, port_f_addr_mask}, {((i < 2) ? i[1:0] : 2'h2), m[i]});
        end
        sel(16'h8000, 3'b001);
    endtask
    // top address, retry counts, stepping to the last address
    task automatic t_prog();
        ahb(1'b1, `OPM_A_CTRL, 32'h1);
        prog(15'h7FFF, 15'h7FFF, 8'hA5);
        chk(rdata, 32'h104);
        ahb(1'b1, `OPM_A_READ, 32'h0);
        idle_wait();
        ahb(1'b0, `OPM_A_READ, 32'h0);
        chk(rdata, 32'hA5);
        ahb(1'b1, `OPM_A_STAT, 32'h6);
        prog(15'h0000, 15'h0001, 8'h3C);
        chk(rdata[2], 1'b0);
        ahb(1'b0, `OPM_A_ADDR, 32'h0);
        chk(rdata, 32'h1);
        ahb(1'b1, `OPM_A_DATA, 32'h0F);
        ahb(1'b1, `OPM_A_READ, 32'h0); // stalls until the byte is done
        idle_wait();
        chk(rdata, 32'h104);
        ahb(1'b0, `OPM_A_READ, 32'h0);
        chk(rdata, 32'h0F);
    endtask
    // cell already holds A5, so 5A can never verify
    task automatic t_fail();
        ahb(1'b1, `OPM_A_STAT, 32'h6);
        prog(15'h7FFF, 15'h7FFF, 8'h5A);
        chk(rdata, {16'h0000, 8'(TRIES), 8'h02});
        ahb(1'b0, 8'h20, 32'h0);
        chk(rdata, 32'h0);
        ahb(1'b1, `OPM_A_CTRL, 32'h0);
        sel(16'h0000, 3'b100);
        chk(cpu_prom_data, 8'h3C);
    endtask
    // main sequence
    initial begin
        {hclk, hresetn, hsel, hwrite, cpu_mm_we, cpu_stop} = 6'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        {haddr, hwdata} = 64'h0;
        cpu_mm_wdata = 8'h00;
        cpu_addr = 16'h0000;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_map();
        t_port();
        t_prog();
        t_fail();
        conclude();
    end
endmodule
